// file: shared/pcstc_pkg.sv
// Constants and types for the PC Card strobe timing control block
package pcstc_pkg;

	// ==========================================================
	// Register map (byte addresses on APB)
	localparam logic [7:0] STRB_OFFSET = 8'h00;
	localparam logic [7:0] STAT_OFFSET = 8'h04;
	localparam int ADDR_W = 8;

	// ==========================================================
	// Strobe timing register layout
	localparam int REG_W = 16;
	localparam logic [15:0] STRB_RESET = 16'h0000;
	localparam logic [15:0] STRB_WMASK = 16'hcfff;
	localparam int A6_WAIT_TOP = 15;
	localparam int A5_WAIT_TOP = 14;
	localparam int A5_TED_B2 = 11;
	localparam int A5_TED_B1 = 7;
	localparam int A5_TED_B0 = 6;
	localparam int A6_TED_B2 = 10;
	localparam int A6_TED_B1 = 5;
	localparam int A6_TED_B0 = 4;
	localparam int A5_TEH_B2 = 9;
	localparam int A5_TEH_B1 = 3;
	localparam int A5_TEH_B0 = 2;
	localparam int A6_TEH_B2 = 8;
	localparam int A6_TEH_B1 = 1;
	localparam int A6_TEH_B0 = 0;

	// ==========================================================
	// Status register layout
	localparam int ST_BUSY = 0;
	localparam int ST_STATE_LO = 1;
	localparam int ST_STATE_HI = 2;
	localparam int ST_AREA6 = 3;
	localparam int ST_WAIT = 4;
	localparam int ST_WRITE = 5;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_W = 6;
	localparam int BEATS_W = 4;
	localparam logic [5:0] MIN_BURST_STATES = 6'h02;

	// ==========================================================
	// Cycle generator states, Gray along the path
	typedef enum logic [1:0] {
		PCSTC_IDLE = 2'b00,
		PCSTC_SETUP = 2'b01,
		PCSTC_STROBE = 2'b11,
		PCSTC_HOLD = 2'b10
	} pcstc_state_t;

endpackage

// file: logic/pcstc_wait_decode.sv
// Wait code decoder: first-cycle waits, burst states, wait pin enable
`timescale 1ns/1ps
module pcstc_wait_decode (
	input wire logic [3:0] code,
	output logic [5:0] first_waits,
	output logic [5:0] burst_states,
	output logic first_wait_en
);

	// ==========================================================
	// Wait count table
	always_comb begin
		case (code)
			4'h0: first_waits = 6'h00;
			4'h1: first_waits = 6'h01;
			4'h2: first_waits = 6'h02;
			4'h3: first_waits = 6'h03;
			4'h4: first_waits = 6'h04;
			4'h5: first_waits = 6'h06;
			4'h6: first_waits = 6'h08;
			4'h7: first_waits = 6'h0a;
			4'h8: first_waits = 6'h0c;
			4'h9: first_waits = 6'h0e;
			4'ha: first_waits = 6'h12;
			4'hb: first_waits = 6'h16;
			4'hc: first_waits = 6'h1a;
			4'hd: first_waits = 6'h1e;
			4'he: first_waits = 6'h22;
			default: first_waits = 6'h26;
		endcase
	end

	// One state above the wait count, never under two
	always_comb begin
		if (first_waits + 6'h01 < pcstc_pkg::MIN_BURST_STATES) begin
			burst_states = pcstc_pkg::MIN_BURST_STATES;
		end else begin
			burst_states = first_waits + 6'h01;
		end
	end

	// First-beat wait pin ignored at code zero only; burst beats always sample it
	assign first_wait_en = (code != 4'h0);

endmodule

// file: logic/pcstc_top.sv
// PC Card strobe timing register and strobe cycle generator
//
// Functional notes
// - 16-bit read/write strobe timing register
// - Power-on clears it; manual reset, standby keep
// - Strobe width comes from wait settings, beat count and card wait pin
// - Area 6 wait code top bit 15
// - Burst state is waits plus one, min two
// - Area 5 wait code top bit 14
// - Bits 13,12 read zero, write zero
// - Area 5 assert delay code plus half
// - Area 6 assert delay code plus half
// - Area 5 address hold code plus half
// - Area 6 address hold code plus half
`timescale 1ns/1ps
module pcstc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic manual_reset_n,
	input wire logic standby,
	input wire logic [2:0] area5_wait_code_low,
	input wire logic [2:0] area6_wait_code_low,
	input wire logic cyc_req,
	input wire logic cyc_area6,
	input wire logic cyc_write,
	input wire logic [3:0] cyc_beats,
	input wire logic card_wait_n,
	output logic cyc_ack,
	output logic cyc_beat,
	output logic cyc_busy,
	output logic addr_en,
	output logic card_oe_n,
	output logic card_we_n
);

	// ==========================================================
	// Declarations
	logic [15:0] strb_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic wait_meta_q;
	logic wait_sync_q;
	pcstc_pkg::pcstc_state_t state_q;
	logic [5:0] cnt_q;
	logic [3:0] beats_left_q;
	logic area6_q;
	logic write_q;
	logic burst_q;
	logic strobe_req_q;
	logic addr_en_q;
	logic ack_q;
	logic beat_q;
	logic oe_n_q;
	logic we_n_q;
	logic [3:0] a5_code;
	logic [3:0] a6_code;
	logic [5:0] a5_first;
	logic [5:0] a6_first;
	logic [5:0] a5_burst;
	logic [5:0] a6_burst;
	logic a5_wen;
	logic a6_wen;
	logic [2:0] ted;
	logic [2:0] teh;
	logic [5:0] first_waits;
	logic [5:0] burst_states;
	logic first_wen;
	logic [2:0] req_ted;
	logic [5:0] req_first;
	logic wait_en;
	logic stall;
	logic accept;
	logic apb_setup;
	logic apb_write;
	logic [31:0] rd_mux;
	logic rd_err;

	// ==========================================================
	// Field helper
	function automatic logic [2:0] field3(
		input logic [15:0] r,
		input int b2,
		input int b1,
		input int b0
	);
		field3 = {r[b2], r[b1], r[b0]};
	endfunction

	// ==========================================================
	// Wait code assembly and decode
	assign a6_code = {strb_q[pcstc_pkg::A6_WAIT_TOP],
		area6_wait_code_low};
	assign a5_code = {strb_q[pcstc_pkg::A5_WAIT_TOP],
		area5_wait_code_low};

	pcstc_wait_decode u_a5_dec (
		.code(a5_code),
		.first_waits(a5_first),
		.burst_states(a5_burst),
		.first_wait_en(a5_wen)
	);

	pcstc_wait_decode u_a6_dec (
		.code(a6_code),
		.first_waits(a6_first),
		.burst_states(a6_burst),
		.first_wait_en(a6_wen)
	);

	// Live selection by the latched area of the running cycle
	always_comb begin
		if (area6_q) begin
			ted = field3(strb_q, pcstc_pkg::A6_TED_B2,
				pcstc_pkg::A6_TED_B1, pcstc_pkg::A6_TED_B0);
			teh = field3(strb_q, pcstc_pkg::A6_TEH_B2,
				pcstc_pkg::A6_TEH_B1, pcstc_pkg::A6_TEH_B0);
			first_waits = a6_first;
			burst_states = a6_burst;
			first_wen = a6_wen;
		end else begin
			ted = field3(strb_q, pcstc_pkg::A5_TED_B2,
				pcstc_pkg::A5_TED_B1, pcstc_pkg::A5_TED_B0);
			teh = field3(strb_q, pcstc_pkg::A5_TEH_B2,
				pcstc_pkg::A5_TEH_B1, pcstc_pkg::A5_TEH_B0);
			first_waits = a5_first;
			burst_states = a5_burst;
			first_wen = a5_wen;
		end
	end

	// Values for the area of a request being accepted
	always_comb begin
		if (cyc_area6) begin
			req_ted = field3(strb_q, pcstc_pkg::A6_TED_B2,
				pcstc_pkg::A6_TED_B1, pcstc_pkg::A6_TED_B0);
			req_first = a6_first;
		end else begin
			req_ted = field3(strb_q, pcstc_pkg::A5_TED_B2,
				pcstc_pkg::A5_TED_B1, pcstc_pkg::A5_TED_B0);
			req_first = a5_first;
		end
	end

	// ==========================================================
	// APB slave, one wait-free access phase
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready_q && pwrite;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr)
			pcstc_pkg::STRB_OFFSET: begin
				rd_mux[15:0] = strb_q & pcstc_pkg::STRB_WMASK;
			end
			pcstc_pkg::STAT_OFFSET: begin
				rd_mux[pcstc_pkg::ST_BUSY] = (state_q != pcstc_pkg::PCSTC_IDLE);
				rd_mux[pcstc_pkg::ST_STATE_HI:pcstc_pkg::ST_STATE_LO] = state_q;
				rd_mux[pcstc_pkg::ST_AREA6] = area6_q;
				rd_mux[pcstc_pkg::ST_WAIT] = !wait_sync_q;
				rd_mux[pcstc_pkg::ST_WRITE] = write_q;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= apb_setup;
			pslverr_q <= apb_setup && rd_err;
			if (apb_setup && !pwrite) begin
				prdata_q <= rd_mux;
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Only power-on reset clears it; manual reset has no path here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strb_q <= pcstc_pkg::STRB_RESET;
		end else if (apb_write && paddr == pcstc_pkg::STRB_OFFSET) begin
			strb_q <= pwdata[15:0] & pcstc_pkg::STRB_WMASK;
		end
	end

	// ==========================================================
	// Wait pin synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_meta_q <= 1'b1;
			wait_sync_q <= 1'b1;
		end else begin
			wait_meta_q <= card_wait_n;
			wait_sync_q <= wait_meta_q;
		end
	end

	// ==========================================================
	// Cycle generator
	// Standby only blocks new cycles; a running one completes
	assign accept = (state_q == pcstc_pkg::PCSTC_IDLE) && cyc_req &&
		!standby && manual_reset_n;
	assign wait_en = burst_q || first_wen;
	assign stall = wait_en && !wait_sync_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			area6_q <= 1'b0;
			write_q <= 1'b0;
		end else if (accept) begin
			area6_q <= cyc_area6;
			write_q <= cyc_write;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= pcstc_pkg::PCSTC_IDLE;
			cnt_q <= 6'h00;
			beats_left_q <= 4'h0;
			burst_q <= 1'b0;
			strobe_req_q <= 1'b0;
			addr_en_q <= 1'b0;
			ack_q <= 1'b0;
			beat_q <= 1'b0;
		end else if (!manual_reset_n) begin
			state_q <= pcstc_pkg::PCSTC_IDLE;
			cnt_q <= 6'h00;
			beats_left_q <= 4'h0;
			burst_q <= 1'b0;
			strobe_req_q <= 1'b0;
			addr_en_q <= 1'b0;
			ack_q <= 1'b0;
			beat_q <= 1'b0;
		end else begin
			ack_q <= 1'b0;
			beat_q <= 1'b0;
			case (state_q)
				pcstc_pkg::PCSTC_IDLE: begin
					if (accept) begin
						addr_en_q <= 1'b1;
						burst_q <= 1'b0;
						if (cyc_beats == 4'h0) begin
							beats_left_q <= 4'h0;
						end else begin
							beats_left_q <= cyc_beats - 4'h1;
						end
						// Zero delay: strobe follows address by half
						if (req_ted == 3'h0) begin
							strobe_req_q <= 1'b1;
							state_q <= pcstc_pkg::PCSTC_STROBE;
							cnt_q <= req_first;
						end else begin
							state_q <= pcstc_pkg::PCSTC_SETUP;
							cnt_q <= {3'h0, req_ted - 3'h1};
						end
					end
				end
				pcstc_pkg::PCSTC_SETUP: begin
					if (cnt_q == 6'h00) begin
						strobe_req_q <= 1'b1;
						state_q <= pcstc_pkg::PCSTC_STROBE;
						cnt_q <= first_waits;
					end else begin
						cnt_q <= cnt_q - 6'h01;
					end
				end
				pcstc_pkg::PCSTC_STROBE: begin
					if (cnt_q != 6'h00) begin
						cnt_q <= cnt_q - 6'h01;
					end else if (!stall) begin
						beat_q <= 1'b1;
						if (beats_left_q != 4'h0) begin
							beats_left_q <= beats_left_q - 4'h1;
							burst_q <= 1'b1;
							cnt_q <= burst_states - 6'h01;
						end else begin
							strobe_req_q <= 1'b0;
							state_q <= pcstc_pkg::PCSTC_HOLD;
							cnt_q <= {3'h0, teh};
						end
					end
				end
				pcstc_pkg::PCSTC_HOLD: begin
					// Address drops code+0.5 cycles after the strobe rises
					if (cnt_q == 6'h00) begin
						addr_en_q <= 1'b0;
						ack_q <= 1'b1;
						burst_q <= 1'b0;
						state_q <= pcstc_pkg::PCSTC_IDLE;
					end else begin
						cnt_q <= cnt_q - 6'h01;
					end
				end
				default: begin
					state_q <= pcstc_pkg::PCSTC_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Half-cycle strobe stage on the falling edge
	// Costs a second clock edge but gives the x.5 offsets exactly
	always_ff @(negedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
		end else begin
			oe_n_q <= !(strobe_req_q && !write_q);
			we_n_q <= !(strobe_req_q && write_q);
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cyc_ack = ack_q;
	assign cyc_beat = beat_q;
	assign cyc_busy = addr_en_q;
	assign addr_en = addr_en_q;
	assign card_oe_n = oe_n_q;
	assign card_we_n = we_n_q;

endmodule

// file: verif/pcstc_asserts.sv
// Port checker for the strobe timing block
`timescale 1ns/1ps
module pcstc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic manual_reset_n,
	input wire logic standby,
	input wire logic cyc_req,
	input wire logic cyc_ack,
	input wire logic addr_en,
	input wire logic card_oe_n,
	input wire logic card_we_n
);
	// =====
	// Relations
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready missing");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_rsv;
		pready && !pwrite && paddr == pcstc_pkg::STRB_OFFSET
			|-> prdata[31:16] == 16'h0000 && prdata[13:12] == 2'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_err; pready && paddr > 8'h04 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no slave error");
	property p_acc;
		cyc_req && !addr_en && !standby && manual_reset_n |=> addr_en;
	endproperty
	a_acc: assert property (p_acc) else $error("cycle not taken");
	// Strobe may only be low while the address is out
	property p_idle; !addr_en |-> card_oe_n && card_we_n; endproperty
	a_idle: assert property (p_idle) else $error("early strobe");
	property p_ack; cyc_ack |-> !addr_en && $past(addr_en); endproperty
	a_ack: assert property (p_ack) else $error("ack misplaced");
	// Abort drops address first, so it is excluded
	property p_hold;
		$rose(card_oe_n && card_we_n) && $past(manual_reset_n) |-> addr_en;
	endproperty
	a_hold: assert property (p_hold) else $error("no hold");
	c_ack: cover property (cyc_ack);
	c_err: cover property (pslverr);
	c_sb: cover property (standby && cyc_req);
endmodule
bind pcstc_top pcstc_chk i_pcstc_chk (
	.pclk(pclk),
	.presetn(presetn),
	.paddr(paddr),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.manual_reset_n(manual_reset_n),
	.standby(standby),
	.cyc_req(cyc_req),
	.cyc_ack(cyc_ack),
	.addr_en(addr_en),
	.card_oe_n(card_oe_n),
	.card_we_n(card_we_n)
);

// file: verif/pcstc_card.sv
// Card model: answers each strobe with a wait of set length
`timescale 1ns/1ps
module pcstc_card (
	input wire logic pclk,
	input wire logic card_oe_n,
	input wire logic card_we_n,
	input wire logic [3:0] hold_waits,
	output logic card_wait_n
);
	// =====
	// Wait answer
	logic [3:0] left_q;
	// Pulled up: reads high whenever released
	assign card_wait_n = (card_oe_n && card_we_n) || left_q == 4'h0;
	always_ff @(posedge pclk) begin
		if (card_oe_n && card_we_n)
			left_q <= hold_waits;
		else if (left_q != 4'h0)
			left_q <= left_q - 4'h1;
	end
endmodule

// file: verif/pcstc_top_test.sv
// Bench for the strobe timing block and its card
`timescale 1ns/1ps
module pcstc_top_test;
	// =====
	// Signals
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic manual_reset_n = 1'h1;
	logic standby = 1'h0;
	logic cyc_req = 1'h0;
	logic cyc_area6 = 1'h0;
	logic cyc_write = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] area5_wait_code_low = 3'h0;
	logic [2:0] area6_wait_code_low = 3'h0;
	logic [3:0] cyc_beats = 4'h1;
	logic [3:0] hold_waits = 4'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, cyc_ack, cyc_beat, cyc_busy, addr_en;
	logic card_oe_n, card_we_n, card_wait_n;
	int n_errors = 0;
	int n_tests = 0;
	int wt[16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 26, 30, 34, 38};
	always #5 pclk = ~pclk;
	pcstc_top i_pcstc_top (
		.pclk(pclk),
		.presetn(presetn),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.manual_reset_n(manual_reset_n),
		.standby(standby),
		.area5_wait_code_low(area5_wait_code_low),
		.area6_wait_code_low(area6_wait_code_low),
		.cyc_req(cyc_req),
		.cyc_area6(cyc_area6),
		.cyc_write(cyc_write),
		.cyc_beats(cyc_beats),
		.card_wait_n(card_wait_n),
		.cyc_ack(cyc_ack),
		.cyc_beat(cyc_beat),
		.cyc_busy(cyc_busy),
		.addr_en(addr_en),
		.card_oe_n(card_oe_n),
		.card_we_n(card_we_n)
	);
	pcstc_card i_pcstc_card (
		.pclk(pclk),
		.card_oe_n(card_oe_n),
		.card_we_n(card_we_n),
		.hold_waits(hold_waits),
		.card_wait_n(card_wait_n)
	);
	// =====
	// Tasks
	task chk(input logic [31:0] seen, exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task test_done;
		$display("Checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task hang;
		n_errors++;
		test_done;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		if (i == 20)
			hang;
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Measures in half cycles, so the half-cycle offsets show
	task cyc(input logic [15:0] rv, input logic a6, w, input logic [2:0] lo,
		input logic [3:0] bt, hw);
		int t, s, r, e, nb, bad, wv, b, len;
		logic [2:0] d, h;
		logic st, pv;
		apb(1'h1, 8'h00, {16'h0000, rv});
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, {16'h0000, rv}, "readback");
		area5_wait_code_low <= lo;
		area6_wait_code_low <= lo;
		hold_waits <= hw;
		cyc_area6 <= a6;
		cyc_write <= w;
		cyc_beats <= bt;
		cyc_req <= 1'h1;
		@(posedge pclk);
		cyc_req <= 1'h0;
		s = -1;
		r = 0;
		e = 0;
		nb = 0;
		bad = 0;
		pv = 1'h1;
		for (t = 0; t < 800 && e == 0; t++) begin
			@(pclk);
			#1;
			st = w ? card_we_n : card_oe_n;
			if (!st && pv && s < 0)
				s = t;
			if (st && !pv)
				r = t;
			if (!addr_en && t > 0)
				e = t;
			if ((w ? card_oe_n : card_we_n) !== 1'h1)
				bad++;
			if (pclk && cyc_beat === 1'h1)
				nb++;
			if (t == 0)
				chk(cyc_busy, 1'h1, "busy");
			pv = st;
		end
		if (e == 0)
			hang;
		chk(cyc_ack, 1'h1, "ack");
		chk(cyc_busy, 1'h0, "busy end");
		d = a6 ? {rv[10], rv[5], rv[4]} : {rv[11], rv[7], rv[6]};
		h = a6 ? {rv[8], rv[1], rv[0]} : {rv[9], rv[3], rv[2]};
		wv = wt[{a6 ? rv[15] : rv[14], lo}];
		b = wv < 1 ? 2 : wv + 1;
		len = 2 * (wv + 1 + (bt - 1) * b);
		chk(s, 2 * d, "assert delay");
		chk(e - r, 2 * h + 1, "address hold");
		if (hw != 4'h0 && wv != 0)
			chk(r - s > len, 1'h1, "wait stretch");
		else
			chk(r - s, len, "strobe width");
		chk(nb, bt, "beats");
		chk(bad, 0, "other strobe");
	endtask
	// =====
	// Sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0, "reset value");
		apb(1'h1, 8'h00, 32'hffffffff);
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0000cfff, "reserved");
		apb(1'h0, 8'h08, 32'h0);
		chk(err, 1'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		standby <= 1'h1;
		cyc_req <= 1'h1;
		repeat (4) @(posedge pclk);
		chk(addr_en, 1'h0, "standby block");
		chk(cyc_busy, 1'h0, "standby busy");
		standby <= 1'h0;
		@(posedge pclk);
		cyc_req <= 1'h0;
		repeat (10) @(posedge pclk);
		chk(card_oe_n, 1'h0, "strobe before abort");
		manual_reset_n <= 1'h0;
		@(posedge pclk);
		manual_reset_n <= 1'h1;
		@(posedge pclk);
		chk(addr_en, 1'h0, "abort address");
		chk(card_oe_n, 1'h1, "abort strobe");
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0000cfff, "kept");
		cyc(16'h0000, 1'h0, 1'h0, 3'h0, 4'h1, 4'h0);
		cyc(16'h4ac4, 1'h0, 1'h1, 3'h3, 4'h1, 4'h0);
		cyc(16'h4bf6, 1'h1, 1'h0, 3'h7, 4'h3, 4'h0);
		cyc(16'h8533, 1'h1, 1'h1, 3'h7, 4'h1, 4'h0);
		apb(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h00000028, "status area6 write");
		chk(err, 1'h0, "status error");
		cyc(16'h0000, 1'h1, 1'h1, 3'h0, 4'h1, 4'h8);
		cyc(16'h0000, 1'h1, 1'h0, 3'h3, 4'h1, 4'h8);
		cyc(16'h0000, 1'h0, 1'h0, 3'h1, 4'h4, 4'h0);
		apb(1'h1, 8'h00, 32'h0000ffff);
		presetn <= 1'h0;
		@(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0, "power on clear");
		apb(1'h0, 8'h04, 32'h0);
		chk(rd, 32'h0, "status reset");
		apb(1'h1, 8'h00, 32'h0);
		test_done;
	end
endmodule
